// ### hdl/motion_cmd_irq_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef MOTION_CMD_IRQ_MAP_SVH
`define MOTION_CMD_IRQ_MAP_SVH
`define OFS_COMMAND 8'h00
`define OFS_MAIN_STATUS 8'h04
`define OFS_EVENT_STATUS 8'h08
`define OFS_INT_MASK 8'h0c
`define OFS_WRITE_DATA_LOW 8'h10
`define OFS_WRITE_DATA_HIGH 8'h14
`define OFS_INPUT_STATUS 8'h18
`define OFS_FILTER_CFG 8'h1c
`define OFS_HOME_CFG 8'h20
`define CMD_SOFT_RESET_BIT 15
`define CMD_CODE_LSB 0
`define CMD_EXT_MODE 8'h60
`define FILTER_CFG_RESET 16'h5f00
`define HOME_CFG_RESET 16'h0000
`define FILTER_DELAY_LSB 0
`define FILTER_GROUP_LSB 8
`define MSTAT_NEXT_SEG_BIT 9
`define MSTAT_STACK_LO_BIT 13
`define MSTAT_STACK_HI_BIT 14
`define EVT_NEXT_SEG_BIT 8
`define EVT_STACK_BIT 9
`define STACK_FROM 2'h2
`define STACK_TO 2'h1
`define CLK_MHZ 250
`define FILTER_TIME_US 512
`define FILTER_CYCLES (`FILTER_TIME_US * `CLK_MHZ)
`endif

// ### hdl/motion_cmd_irq_pkg.sv
// Types shared by the host command and interrupt block.
package motion_cmd_irq_pkg;
    typedef logic [15:0] word_t;
    typedef struct packed {
        logic [7:0] addr;
        logic write;
    } bus_req_s;
    typedef struct packed {
        logic gen_input_3;
        logic ext_op_minus_in;
        logic ext_op_plus_in;
        logic servo_alarm_in;
        logic in_position_in;
        logic gen_input_2;
        logic gen_input_1;
        logic gen_input_0;
        logic limit_minus_in;
        logic limit_plus_in;
        logic emergency_stop_in;
    } pins_s;
endpackage

// ### hdl/motion_cmd_irq.sv
// Host command decoder, input filters and interrupt logic.
//
// What this block does
// - Command code 60h loads filter config and home config in one step.
// - Writing one to command bit 15 soft-resets the block.
// - Each input passes an integral filter, enabled per group, delay chosen.
// - Next-segment bit 9 of main status rises and may interrupt.
// - Stack count falling from 2 to 1 interrupts; count readable.
// - Reading event status clears the events it reported.
`timescale 1ns/1ns
`include "motion_cmd_irq_map.svh"

module motion_cmd_irq #(
    parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
    input wire logic hclk, // Bus clock.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // Slave select.
    input wire logic [7:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write when high.
    input wire logic [2:0] hsize, // Transfer size, word only.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    output logic [31:0] hrdata, // Read data.
    output logic hreadyout, // Always ready.
    output logic hresp, // Always OKAY.
    input wire motion_cmd_irq_pkg::pins_s ext_pins, // Raw input pins.
    input wire logic [7:0] core_event, // Motion core event pulses.
    input wire logic next_segment_ready, // Core: next segment writable.
    input wire logic [1:0] stack_count, // Core: pattern stack count.
    output motion_cmd_irq_pkg::pins_s filt_pins, // Filtered inputs.
    output logic [15:0] home_cfg, // Home-search settings to core.
    output logic irq // Interrupt request.
);

    localparam int NPIN = 11;

    // Decodes a register hit; used by both the write and read paths.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // Group of each pin, in the order the pin struct packs them from bit 0.
    function automatic int pin_group(input int i);
        case (i)
            5: return 1;
            6, 7: return 2;
            8, 9: return 3;
            10: return 4;
            default: return 0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, read data registered at address phase.

    motion_cmd_irq_pkg::bus_req_s req_ff, nxt_req;
    logic wr_pend_ff, nxt_wr_pend;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [15:0] wdl_ff, nxt_wdl, wdh_ff, nxt_wdh;
    logic [15:0] filt_cfg_ff, nxt_filt_cfg, home_cfg_ff, nxt_home_cfg;
    logic [9:0] evt_ff, nxt_evt, mask_ff, nxt_mask, evt_set;
    logic seg_q_ff, nxt_seg_q;
    logic [1:0] stk_q_ff, nxt_stk_q;
    logic [NPIN-1:0] filt_q;
    logic acc, wr_now, soft_rst, ext_cmd, rd_evt;
    logic [15:0] wd, mstat;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign home_cfg = home_cfg_ff;
    assign filt_pins = filt_q;
    assign irq = |(evt_ff & mask_ff);

    // Address decode, command actions, event capture and read mux.
    always_comb begin
        acc = hsel & htrans[1] & hready;
        wd = hwdata[15:0];
        wr_now = wr_pend_ff;
        nxt_req = req_ff;
        nxt_wr_pend = 1'b0;
        if (acc) begin
            nxt_req.addr = haddr;
            nxt_req.write = hwrite;
            nxt_wr_pend = hwrite;
        end
        soft_rst = wr_now & hit(req_ff.addr, `OFS_COMMAND)
            & wd[`CMD_SOFT_RESET_BIT];
        ext_cmd = wr_now & hit(req_ff.addr, `OFS_COMMAND) & ~soft_rst
            & (wd[`CMD_CODE_LSB +: 8] == `CMD_EXT_MODE);
        nxt_wdl = (wr_now & hit(req_ff.addr, `OFS_WRITE_DATA_LOW))
            ? wd : wdl_ff;
        nxt_wdh = (wr_now & hit(req_ff.addr, `OFS_WRITE_DATA_HIGH))
            ? wd : wdh_ff;
        nxt_mask = (wr_now & hit(req_ff.addr, `OFS_INT_MASK))
            ? wd[9:0] : mask_ff;
        nxt_filt_cfg = filt_cfg_ff;
        nxt_home_cfg = home_cfg_ff;
        if (ext_cmd) begin
            nxt_filt_cfg = wdl_ff;
            nxt_home_cfg = wdh_ff;
        end
        // Events fire on rising edge of next-segment and on stack 2 to 1.
        nxt_seg_q = next_segment_ready;
        nxt_stk_q = stack_count;
        evt_set = {(stk_q_ff == `STACK_FROM) && (stack_count == `STACK_TO),
            next_segment_ready & ~seg_q_ff, core_event};
        rd_evt = acc & ~hwrite & hit(haddr, `OFS_EVENT_STATUS);
        // A set in the clearing cycle survives: the read saw the old value.
        nxt_evt = ((rd_evt ? 10'h000 : evt_ff) | evt_set);
        if (soft_rst) begin
            nxt_filt_cfg = `FILTER_CFG_RESET;
            nxt_home_cfg = `HOME_CFG_RESET;
            nxt_mask = 10'h000;
            nxt_evt = evt_set;
            nxt_wdl = 16'h0000;
            nxt_wdh = 16'h0000;
        end
        mstat = 16'h0000;
        mstat[`MSTAT_NEXT_SEG_BIT] = next_segment_ready;
        mstat[`MSTAT_STACK_LO_BIT] = stack_count[0];
        mstat[`MSTAT_STACK_HI_BIT] = stack_count[1];
        // Writable registers read from next values so read-after-write works.
        nxt_rdata = rdata_ff;
        if (acc & ~hwrite) begin
            unique case (haddr)
                `OFS_MAIN_STATUS: nxt_rdata = {16'h0000, mstat};
                `OFS_EVENT_STATUS: nxt_rdata = {22'h000000, evt_ff};
                `OFS_INT_MASK: nxt_rdata = {22'h000000, nxt_mask};
                `OFS_WRITE_DATA_LOW: nxt_rdata = {16'h0000, nxt_wdl};
                `OFS_WRITE_DATA_HIGH: nxt_rdata = {16'h0000, nxt_wdh};
                `OFS_INPUT_STATUS: nxt_rdata = {21'h000000, filt_q};
                `OFS_FILTER_CFG: nxt_rdata = {16'h0000, nxt_filt_cfg};
                `OFS_HOME_CFG: nxt_rdata = {16'h0000, nxt_home_cfg};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // Register stage of the bus, command and interrupt state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_ff <= '0;
            wr_pend_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            wdl_ff <= 16'h0000;
            wdh_ff <= 16'h0000;
            filt_cfg_ff <= `FILTER_CFG_RESET;
            home_cfg_ff <= `HOME_CFG_RESET;
            evt_ff <= 10'h000;
            mask_ff <= 10'h000;
            seg_q_ff <= 1'b0;
            stk_q_ff <= 2'h0;
        end else begin
            req_ff <= nxt_req;
            wr_pend_ff <= nxt_wr_pend;
            rdata_ff <= nxt_rdata;
            wdl_ff <= nxt_wdl;
            wdh_ff <= nxt_wdh;
            filt_cfg_ff <= nxt_filt_cfg;
            home_cfg_ff <= nxt_home_cfg;
            evt_ff <= nxt_evt;
            mask_ff <= nxt_mask;
            seg_q_ff <= nxt_seg_q;
            stk_q_ff <= nxt_stk_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input filters: two-stage sync, then a saturating integrator.

    logic [16:0] thr;
    logic [2:0] dly;

    // Longer delay codes halve the window; a shortened window floors at 1.
    always_comb begin
        dly = filt_cfg_ff[`FILTER_DELAY_LSB +: 3];
        thr = 17'(FILTER_CYCLES >> dly);
        if (thr == 17'h00000) begin
            thr = 17'h00001;
        end
    end

    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_filt
            logic s1_ff, s2_ff, q_ff, nxt_q;
            logic [16:0] cnt_ff, nxt_cnt;
            logic en;

            // Integrate toward the synced level; a glitch shorter than the
            // window never reaches either end, so the output holds.
            always_comb begin
                en = filt_cfg_ff[`FILTER_GROUP_LSB + pin_group(i)];
                nxt_cnt = cnt_ff;
                nxt_q = q_ff;
                if (!en) begin
                    nxt_q = s2_ff;
                    nxt_cnt = s2_ff ? thr : 17'h00000;
                end else if (s2_ff) begin
                    nxt_cnt = (cnt_ff >= thr) ? thr : cnt_ff + 17'h00001;
                    nxt_q = (nxt_cnt == thr) ? 1'b1 : q_ff;
                end else begin
                    nxt_cnt = (cnt_ff == 17'h00000) ? 17'h00000
                        : cnt_ff - 17'h00001;
                    nxt_q = (nxt_cnt == 17'h00000) ? 1'b0 : q_ff;
                end
                // Soft reset empties the integrator but keeps the output.
                if (soft_rst) begin
                    nxt_cnt = 17'h00000;
                end
            end

            // The first sync stage feeds only the second.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_ff <= 1'b1;
                    s2_ff <= 1'b1;
                    q_ff <= 1'b1;
                    cnt_ff <= 17'h00000;
                end else begin
                    s1_ff <= ext_pins[i];
                    s2_ff <= s1_ff;
                    q_ff <= nxt_q;
                    cnt_ff <= nxt_cnt;
                end
            end
            assign filt_q[i] = q_ff;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_EXT_LOAD: assert property (ext_cmd |=>
        filt_cfg_ff == $past(wdl_ff) && home_cfg_ff == $past(wdh_ff))
        else $error("extension command did not load both settings");
    AST_SOFT_RST: assert property (soft_rst |=>
        filt_cfg_ff == `FILTER_CFG_RESET && mask_ff == 10'h000)
        else $error("soft reset did not restore defaults");
    AST_FILT_OFF: assert property (!filt_cfg_ff[`FILTER_GROUP_LSB]
        ##1 !filt_cfg_ff[`FILTER_GROUP_LSB]
        |-> filt_q[0] == $past(g_filt[0].s2_ff))
        else $error("disabled filter did not pass input");
    AST_SEG_SET: assert property ($rose(next_segment_ready)
        |=> evt_ff[`EVT_NEXT_SEG_BIT])
        else $error("next segment event lost");
    AST_STK_SET: assert property (stack_count == `STACK_TO
        && $past(stack_count) == `STACK_FROM |=> evt_ff[`EVT_STACK_BIT])
        else $error("stack 2 to 1 event lost");
    AST_RD_CLR: assert property (rd_evt |=>
        evt_ff == $past(evt_set) && rdata_ff[9:0] == $past(evt_ff))
        else $error("event read did not clear or report");
    // A clearing read that meets no new event must leave nothing pending.
    AST_IRQ: assert property (rd_evt && evt_set == 10'h000
        |=> !irq)
        else $error("interrupt still high after clearing read");
    AST_MSTAT: assert property (acc && !hwrite
        && haddr == `OFS_MAIN_STATUS |=> rdata_ff[`MSTAT_STACK_HI_BIT]
        == $past(stack_count[1]) && rdata_ff[`MSTAT_NEXT_SEG_BIT]
        == $past(next_segment_ready))
        else $error("main status read wrong");

    COV_EXT: cover property (ext_cmd);
    COV_IRQ_CLR: cover property (irq ##1 rd_evt ##1 !irq);
    COV_STK: cover property (evt_set[`EVT_STACK_BIT] && rd_evt);

endmodule // motion_cmd_irq

// ### tb/test_motion_ctrl_host_cmd_irq.sv
// Self-checking bench for the host command and interrupt block.
`timescale 1ns/1ns
`include "motion_cmd_irq_map.svh"

module test_motion_ctrl_host_cmd_irq;
    localparam int FILT = 32;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, nsr;
    logic [7:0] haddr, core_event, ev;
    logic [1:0] htrans, stack_count;
    logic [31:0] hwdata, hrdata, rd;
    logic [15:0] home_cfg, wdl, wdh;
    motion_cmd_irq_pkg::pins_s ext_pins, filt_pins, pins;
    int n_fail, samples_checked, cycles;
    integer seed;

    ////////////////////////////////////////////////////////////////////////
    // The small filter window keeps the run short.
    motion_cmd_irq #(.FILTER_CYCLES(FILT)) motion_cmd_irq_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_pins(ext_pins), .core_event(core_event),
        .next_segment_ready(nsr), .stack_count(stack_count),
        .filt_pins(filt_pins), .home_cfg(home_cfg), .irq(irq));

    // Clock of 4 ns period.
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Cuts a hang short; the ceiling is well above the planned run.
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; waits on hready, never on a count.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
        chk(32'(hresp), 32'h0); // Response is always OKAY.
    endtask

    // Raises a one-cycle event pulse from the motion core.
    task automatic pulse(input logic [7:0] e);
        @(posedge hclk);
        core_event <= e;
        @(posedge hclk);
        core_event <= 8'h00;
        repeat (2) @(posedge hclk);
        #1;
    endtask

    // Main status as the host should see it.
    function automatic logic [31:0] mstat(input logic n, input logic [1:0] s);
        return 32'(n) << `MSTAT_NEXT_SEG_BIT | 32'(s) << `MSTAT_STACK_LO_BIT;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, filters, extension load, events, soft reset.
    initial begin
        seed = 32'hf046;
        {hsel, hwrite, nsr, n_fail, samples_checked, cycles} = '0;
        {haddr, htrans, hwdata, core_event, stack_count} = '0;
        ext_pins = '1;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(`OFS_FILTER_CFG, 32'h5f00);
        rd_chk(`OFS_HOME_CFG, 32'h0);
        rd_chk(8'h40, 32'h0);
        // Enabled filter must hold a change back for a whole window, so
        // the integrators fill up first and bit 0 always falls.
        repeat (FILT) @(posedge hclk);
        pins = 11'($random(seed)) & 11'h7fe;
        ext_pins <= pins;
        repeat (FILT + 1) @(posedge hclk);
        #1 chk(32'(filt_pins), 32'h7ff);
        @(posedge hclk);
        #1 chk(32'(filt_pins), 32'(pins));
        rd_chk(`OFS_INPUT_STATUS, 32'(pins));
        // Extension load: documented values first, then random, then off.
        for (int i = 0; i < 4; i++) begin
            wdl = (i == 0) ? 16'h5f00 : (i == 3) ? 16'h0 : 16'($random(seed));
            wdh = (i == 0) ? 16'h0 : 16'($random(seed));
            wr(`OFS_WRITE_DATA_LOW, 32'(wdl));
            wr(`OFS_WRITE_DATA_HIGH, 32'(wdh));
            wr(`OFS_COMMAND, 32'h0f60);
            #1 chk(32'(home_cfg), 32'(wdh));
            rd_chk(`OFS_FILTER_CFG, 32'(wdl));
        end
        // Groups now disabled: a change passes after the synchronizer.
        pins = ~pins;
        ext_pins <= pins;
        repeat (4) @(posedge hclk);
        #1 chk(32'(filt_pins), 32'(pins));
        // Unmasked events raise irq; a read reports and clears them.
        wr(`OFS_INT_MASK, 32'h3ff);
        ev = 8'($random(seed)) | 8'h01;
        pulse(ev);
        chk(32'(irq), 32'h1);
        rd_chk(`OFS_EVENT_STATUS, 32'(ev));
        #1 chk(32'(irq), 32'h0);
        rd_chk(`OFS_EVENT_STATUS, 32'h0);
        // Masked events are recorded but keep irq low.
        wr(`OFS_INT_MASK, 32'h0);
        pulse(ev);
        chk(32'(irq), 32'h0);
        rd_chk(`OFS_EVENT_STATUS, 32'(ev));
        wr(`OFS_INT_MASK, 32'h3ff);
        // Next-segment rise.
        @(posedge hclk);
        nsr <= 1'b1;
        repeat (3) @(posedge hclk);
        #1 chk(32'(irq), 32'h1);
        // The host clears at once and reads event causes before status.
        rd_chk(`OFS_EVENT_STATUS, 32'h100);
        #1 chk(32'(irq), 32'h0);
        rd_chk(`OFS_MAIN_STATUS, mstat(1'b1, 2'h0));
        // Stack count falls to 1 from 2 (event) and from 3 (no event).
        for (int f = 2; f < 4; f++) begin
            @(posedge hclk);
            stack_count <= 2'(f);
            repeat (3) @(posedge hclk);
            xfer(1'b0, `OFS_EVENT_STATUS, 32'h0, rd);
            stack_count <= 2'h1;
            repeat (3) @(posedge hclk);
            rd_chk(`OFS_EVENT_STATUS, (f == 2) ? 32'h200 : 32'h0);
            rd_chk(`OFS_MAIN_STATUS, mstat(1'b1, 2'h1));
        end
        // Soft reset restores defaults, clears mask, events and write data.
        pulse(ev);
        chk(32'(irq), 32'h1);
        wr(`OFS_WRITE_DATA_LOW, 32'h1234);
        wr(`OFS_COMMAND, 32'h8000);
        #1 chk(32'(home_cfg), 32'h0);
        chk(32'(irq), 32'h0);
        rd_chk(`OFS_FILTER_CFG, 32'h5f00);
        rd_chk(`OFS_INT_MASK, 32'h0);
        rd_chk(`OFS_EVENT_STATUS, 32'h0);
        rd_chk(`OFS_WRITE_DATA_LOW, 32'h0);
        pulse(ev);
        chk(32'(irq), 32'h0);
        print_verdict();
    end
endmodule // test_motion_ctrl_host_cmd_irq
